/* hw/fsr_status_two.sv */
// Second status register of the serial flash with its command handling
`timescale 1ns/1ns
`default_nettype none
module fsr_status_two
  import fsr_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  output logic            o_so,
  output logic            o_so_oe,
  input  wire logic       i_wp_n,
  input  wire logic       i_hold_n,
  input  wire logic       i_reset_func_sel,
  input  wire logic       i_jedec_reset,
  input  wire logic       i_protect_select_lo,
  input  wire logic       i_permanent_lock_bit,
  input  wire logic       i_addr_check_valid,
  input  wire logic       i_addr_in_map,
  input  wire logic       i_otp_prog_valid,
  input  wire logic [1:0] i_otp_prog_reg,
  input  wire logic [6:0] i_otp_prog_byte,
  output logic [7:0]      o_status_two,
  output logic            o_write_latch,
  output logic            o_io2_data_mode,
  output logic            o_io3_data_mode,
  output logic            o_write_guard_active,
  output logic            o_hold_active,
  output logic            o_quad_cmd_reject,
  output logic            o_status_write_blocked,
  output logic            o_soft_reset,
  output logic            o_addr_protected,
  output logic            o_addr_check_done,
  output logic            o_otp_prog_accept,
  output logic            o_otp_prog_reject
);

  fsr_spi_if     spi ();
  fsr_frame_type frame_state;
  logic [7:0]    cmd;
  logic [7:0]    data;
  logic          wp_s1, wp_s2;
  logic          hold_s1, hold_s2;
  logic          write_latch;
  logic          suspended_flag;
  logic          inverse_protect;
  logic          quad_pin_enable;
  logic          protect_select_hi;
  logic [2:0]    otp_lock_bits;
  logic [2:0]    otp_lock_set;
  logic          reset_armed;
  logic          exec;
  logic          exec_one;
  logic          exec_write;
  logic          wp_level;
  logic          write_ok;
  logic          pin_reset;
  logic          soft_reset;
  logic          any_reset;
  logic [7:0]    status_two;

  fsr_spi_link u_link (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_sck     (i_sck),
    .i_cs_n    (i_cs_n),
    .i_si      (i_si),
    .o_so      (o_so),
    .o_so_oe   (o_so_oe),
    .bus       (spi.link)
  );

  fsr_guard u_guard (
    .i_sys_clk          (i_sys_clk),
    .i_reset            (i_reset),
    .i_inverse_protect  (inverse_protect),
    .i_otp_lock_bits    (otp_lock_bits),
    .i_addr_check_valid (i_addr_check_valid),
    .i_addr_in_map      (i_addr_in_map),
    .i_otp_prog_valid   (i_otp_prog_valid),
    .i_otp_prog_reg     (i_otp_prog_reg),
    .i_otp_prog_byte    (i_otp_prog_byte),
    .o_addr_protected   (o_addr_protected),
    .o_addr_check_done  (o_addr_check_done),
    .o_otp_prog_accept  (o_otp_prog_accept),
    .o_otp_prog_reject  (o_otp_prog_reject),
    .o_otp_lock_set     (otp_lock_set)
  );

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wp_s1   <= 1'b1;
      wp_s2   <= 1'b1;
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
    end else begin
      wp_s1   <= i_wp_n;
      wp_s2   <= wp_s1;
      hold_s1 <= i_hold_n;
      hold_s2 <= hold_s1;
    end
  end

  // Pin roles follow quad enable
  assign o_io2_data_mode      = quad_pin_enable;
  assign o_io3_data_mode      = quad_pin_enable;
  assign o_write_guard_active = ~quad_pin_enable & ~wp_s2;
  assign o_hold_active        = ~quad_pin_enable & ~i_reset_func_sel & ~hold_s2 & spi.frame_active;
  assign pin_reset            = ~quad_pin_enable & i_reset_func_sel & ~hold_s2;
  assign wp_level             = quad_pin_enable | wp_s2;

  // Frame tracking: command byte, first data byte, then anything more
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      frame_state <= FR_WAIT_CMD;
      cmd         <= 8'h00;
      data        <= 8'h00;
    // Held until frame_end, which trails the select rise, so commands still execute
    end else if (spi.frame_end) begin
      frame_state <= FR_WAIT_CMD;
    end else if (spi.byte_valid) begin
      case (frame_state)
        FR_WAIT_CMD: begin
          cmd         <= spi.rx_byte;
          frame_state <= FR_GOT_CMD;
        end
        FR_GOT_CMD: begin
          data        <= spi.rx_byte;
          frame_state <= FR_GOT_DATA;
        end
        FR_GOT_DATA: frame_state <= FR_OVERRUN;
        FR_OVERRUN:  frame_state <= FR_OVERRUN;
        default:     frame_state <= FR_WAIT_CMD;
      endcase
    end
  end

  // Commands act only once the whole command has been clocked in
  assign exec       = spi.frame_end && (frame_state != FR_WAIT_CMD);
  assign exec_one   = spi.frame_end && (frame_state == FR_GOT_CMD);
  assign exec_write = exec && (frame_state != FR_GOT_CMD) && (cmd == CMD_WRITE_STATUS2);
  assign write_ok   = write_latch && !protect_select_hi &&
                      !(i_protect_select_lo && !wp_level);
  assign soft_reset = exec_one && (cmd == CMD_RESET) && reset_armed;
  assign any_reset  = soft_reset | pin_reset | i_jedec_reset;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      reset_armed <= 1'b0;
    end else if (exec) begin
      reset_armed <= exec_one && (cmd == CMD_RESET_ENABLE);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      write_latch <= 1'b0;
    end else if (any_reset) begin
      write_latch <= 1'b0;
    end else if (exec_one && cmd == CMD_WRITE_ENABLE) begin
      write_latch <= 1'b1;
    end else if ((exec_one && cmd == CMD_WRITE_DISABLE) || exec_write) begin
      write_latch <= 1'b0;
    end
  end

  // Suspend set wins over a coincident clear
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      suspended_flag <= 1'b0;
    end else if (exec_one && cmd == CMD_SUSPEND) begin
      suspended_flag <= 1'b1;
    end else if (any_reset || (exec_one && cmd == CMD_RESUME)) begin
      suspended_flag <= 1'b0;
    end
  end

  // Writable fields; the reserved bit is never stored
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      inverse_protect   <= STATUS_TWO_RESET[BIT_INVERSE];
      quad_pin_enable   <= STATUS_TWO_RESET[BIT_QUAD];
      protect_select_hi <= STATUS_TWO_RESET[BIT_SELECT_HI];
    end else if (any_reset) begin
      protect_select_hi <= protect_select_hi & i_protect_select_lo & i_permanent_lock_bit;
    end else if (exec_write && write_ok) begin
      inverse_protect   <= data[BIT_INVERSE];
      quad_pin_enable   <= data[BIT_QUAD];
      protect_select_hi <= data[BIT_SELECT_HI];
    end
  end

  // One-time lock bits only ever set
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      otp_lock_bits <= LOCK_RESET;
    end else begin
      otp_lock_bits <= otp_lock_bits | otp_lock_set;
    end
  end

  assign status_two = {suspended_flag, inverse_protect, otp_lock_bits, 1'b0,
                       quad_pin_enable, protect_select_hi};

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_status_two           <= STATUS_TWO_RESET;
      spi.tx_byte            <= STATUS_TWO_RESET;
      spi.tx_en              <= 1'b0;
      o_quad_cmd_reject      <= 1'b0;
      o_status_write_blocked <= 1'b0;
      o_soft_reset           <= 1'b0;
    end else begin
      o_status_two           <= status_two;
      spi.tx_byte            <= status_two;
      spi.tx_en              <= spi.frame_active && (frame_state != FR_WAIT_CMD) && (cmd == CMD_READ_STATUS2);
      o_quad_cmd_reject      <= spi.byte_valid && (frame_state == FR_WAIT_CMD) &&
                                fsr_is_quad_cmd(spi.rx_byte) && !quad_pin_enable;
      o_status_write_blocked <= exec_write && !write_ok;
      o_soft_reset           <= soft_reset;
    end
  end

  assign o_write_latch = write_latch;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  suspend_set_a: assert property (exec_one && cmd == CMD_SUSPEND |=> ##1 o_status_two[BIT_SUSPENDED])
    else $error("suspend did not set flag");
  suspend_clear_a: assert property ((exec_one && cmd == CMD_RESUME) || soft_reset |=> !suspended_flag)
    else $error("resume or reset left flag set");
  inverse_write_a: assert property (exec_write && write_ok |=> inverse_protect == $past(data[BIT_INVERSE]))
    else $error("inverse bit not written");
  lock_sticky_a: assert property (##1 (($past(otp_lock_bits) & ~otp_lock_bits) == 3'h0))
    else $error("lock bit cleared");
  lock_set_a: assert property (i_otp_prog_valid && i_otp_prog_reg == 2'h1 && !otp_lock_bits[0]
                               && i_otp_prog_byte == OTP_LAST_BYTE |=> ##1 otp_lock_bits[0])
    else $error("last byte did not lock");
  reg_zero_a: assert property (i_otp_prog_valid && i_otp_prog_reg == 2'h0
                               |=> o_otp_prog_reject && !o_otp_prog_accept)
    else $error("register zero accepted");
  locked_reject_a: assert property (i_otp_prog_valid && i_otp_prog_reg == 2'h3 && otp_lock_bits[2]
                                    |=> o_otp_prog_reject)
    else $error("locked register accepted");
  reserved_zero_a: assert property (!o_status_two[BIT_RESERVED] && !spi.tx_byte[BIT_RESERVED])
    else $error("reserved bit nonzero");
  quad_pins_a: assert property (quad_pin_enable |-> !o_write_guard_active && !o_hold_active && !pin_reset)
    else $error("control pin active in quad mode");
  quad_reject_a: assert property (spi.byte_valid && frame_state == FR_WAIT_CMD && spi.rx_byte == CMD_XIP_READ
                                  && !quad_pin_enable |=> o_quad_cmd_reject)
    else $error("quad command not flagged");
  sw_write_a: assert property (exec_write && write_latch && !protect_select_hi && !i_protect_select_lo
                               && !any_reset |=> quad_pin_enable == $past(data[BIT_QUAD]))
    else $error("unprotected write lost");
  hw_block_a: assert property (exec_write && i_protect_select_lo && !wp_level && !any_reset
                               |=> $stable(quad_pin_enable) && $stable(inverse_protect) && o_status_write_blocked)
    else $error("guarded write went through");
  lockdown_a: assert property (exec_write && protect_select_hi && !any_reset
                               |=> $stable(quad_pin_enable) && $stable(protect_select_hi))
    else $error("lockdown write went through");
  lock_release_a: assert property (soft_reset && !(i_protect_select_lo && i_permanent_lock_bit)
                                   |=> !protect_select_hi)
    else $error("reset kept lockdown");
  addr_swap_a: assert property (i_addr_check_valid |=> ##1 o_addr_protected == ($past(i_addr_in_map, 2)
                                ^ $past(inverse_protect, 2)))
    else $error("address check ignores inverse");
  latch_clear_a: assert property (exec_write && !any_reset |=> !write_latch)
    else $error("write status left latch set");
  pin_reset_a: assert property (!quad_pin_enable && i_reset_func_sel && !hold_s2 |=> !write_latch)
    else $error("reset pin ignored");

  suspend_c: cover property (exec_one && cmd == CMD_SUSPEND ##[1:200] exec_one && cmd == CMD_RESUME);
  write_c: cover property (exec_write && write_ok);
  lock_c: cover property (|otp_lock_set);
  reject_c: cover property (o_quad_cmd_reject);
  blocked_c: cover property (o_status_write_blocked);

endmodule : fsr_status_two
`default_nettype wire

/* hw/fsr_pkg.sv */
// Constants and types shared by the second status register block
package fsr_pkg;

  // Status register two field positions
  localparam int unsigned BIT_SUSPENDED  = 7;
  localparam int unsigned BIT_INVERSE    = 6;
  localparam int unsigned BIT_LOCK_HI    = 5;
  localparam int unsigned BIT_LOCK_LO    = 3;
  localparam int unsigned BIT_RESERVED   = 2;
  localparam int unsigned BIT_QUAD       = 1;
  localparam int unsigned BIT_SELECT_HI  = 0;
  localparam int unsigned LOCK_COUNT     = 3;

  localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
  localparam logic [2:0] LOCK_RESET       = 3'h0;
  localparam logic [6:0] OTP_LAST_BYTE    = 7'h7F;

  // Serial command codes
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS2  = 8'h35;
  localparam logic [7:0] CMD_WRITE_STATUS2 = 8'h31;
  localparam logic [7:0] CMD_SUSPEND       = 8'h75;
  localparam logic [7:0] CMD_RESUME        = 8'h7A;
  localparam logic [7:0] CMD_RESET_ENABLE  = 8'h66;
  localparam logic [7:0] CMD_RESET         = 8'h99;
  localparam logic [7:0] CMD_QUAD_OUT_READ = 8'h6B;
  localparam logic [7:0] CMD_XIP_READ      = 8'hEB;
  localparam logic [7:0] CMD_XIP_READ_DW   = 8'hE7;
  localparam logic [7:0] CMD_QUAD_PROGRAM  = 8'h32;
  localparam logic [7:0] CMD_BURST_WRAP    = 8'h77;
  localparam logic [7:0] CMD_QUAD_ID_READ  = 8'h94;

  typedef enum logic [1:0] {
    FR_WAIT_CMD,
    FR_GOT_CMD,
    FR_GOT_DATA,
    FR_OVERRUN
  } fsr_frame_type;

  function automatic logic fsr_is_quad_cmd(input logic [7:0] code);
    fsr_is_quad_cmd = (code == CMD_QUAD_OUT_READ) || (code == CMD_XIP_READ) ||
                      (code == CMD_XIP_READ_DW) || (code == CMD_QUAD_PROGRAM) ||
                      (code == CMD_BURST_WRAP) || (code == CMD_QUAD_ID_READ);
  endfunction : fsr_is_quad_cmd

endpackage : fsr_pkg

/* hw/fsr_spi_if.sv */
// Byte-level carrier between the serial front end and the register core
`timescale 1ns/1ns
`default_nettype none
interface fsr_spi_if;
  logic       byte_valid;
  logic [7:0] rx_byte;
  logic       frame_end;
  logic       frame_active;
  logic [7:0] tx_byte;
  logic       tx_en;

  modport link (output byte_valid, output rx_byte, output frame_end, output frame_active,
                input tx_byte, input tx_en);
  modport core (input byte_valid, input rx_byte, input frame_end, input frame_active,
                output tx_byte, output tx_en);
endinterface : fsr_spi_if
`default_nettype wire

/* hw/fsr_spi_link.sv */
// Serial front end: samples the link clock, shifts bytes in and out
`timescale 1ns/1ns
`default_nettype none
module fsr_spi_link
  import fsr_pkg::*;
(
  input  wire logic   i_sys_clk,
  input  wire logic   i_reset,
  input  wire logic   i_sck,
  input  wire logic   i_cs_n,
  input  wire logic   i_si,
  output logic        o_so,
  output logic        o_so_oe,
  fsr_spi_if.link     bus
);

  logic       sck_s1, sck_s2, sck_s3;
  logic       cs_n_s1, cs_n_s2, cs_n_s3;
  logic       si_s1, si_s2;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic       sck_rise;
  logic       sck_fall;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      sck_s3  <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      cs_n_s3 <= 1'b1;
      si_s1   <= 1'b0;
      si_s2   <= 1'b0;
    end else begin
      sck_s1  <= i_sck;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      cs_n_s1 <= i_cs_n;
      cs_n_s2 <= cs_n_s1;
      cs_n_s3 <= cs_n_s2;
      si_s1   <= i_si;
      si_s2   <= si_s1;
    end
  end

  assign sck_rise = sck_s2 & ~sck_s3 & ~cs_n_s2;
  assign sck_fall = ~sck_s2 & sck_s3 & ~cs_n_s2;
  assign bus.frame_active = ~cs_n_s2;

  // Receive shifter, MSB first
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      bit_cnt        <= 3'h0;
      rx_sh          <= 8'h00;
      bus.rx_byte    <= 8'h00;
      bus.byte_valid <= 1'b0;
      bus.frame_end  <= 1'b0;
    end else begin
      bus.byte_valid <= 1'b0;
      bus.frame_end  <= cs_n_s2 & ~cs_n_s3;
      if (cs_n_s2) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        rx_sh   <= {rx_sh[6:0], si_s2};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          bus.rx_byte    <= {rx_sh[6:0], si_s2};
          bus.byte_valid <= 1'b1;
        end
      end
    end
  end

  // Transmit shifter, reloaded on the falling edge that opens each byte
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_sh <= 8'h00;
    end else if (cs_n_s2) begin
      tx_sh <= 8'h00;
    end else if (sck_fall) begin
      tx_sh <= (bit_cnt == 3'h0) ? bus.tx_byte : {tx_sh[6:0], 1'b0};
    end
  end

  assign o_so    = tx_sh[7];
  assign o_so_oe = ~cs_n_s2 & bus.tx_en;

endmodule : fsr_spi_link
`default_nettype wire

/* hw/fsr_guard.sv */
// Address protection and one-time security register program checks
`timescale 1ns/1ns
`default_nettype none
module fsr_guard
  import fsr_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_inverse_protect,
  input  wire logic [2:0] i_otp_lock_bits,
  input  wire logic       i_addr_check_valid,
  input  wire logic       i_addr_in_map,
  input  wire logic       i_otp_prog_valid,
  input  wire logic [1:0] i_otp_prog_reg,
  input  wire logic [6:0] i_otp_prog_byte,
  output logic            o_addr_protected,
  output logic            o_addr_check_done,
  output logic            o_otp_prog_accept,
  output logic            o_otp_prog_reject,
  output logic [2:0]      o_otp_lock_set
);

  logic reg_locked;

  // Register zero is factory content and always locked
  assign reg_locked = (i_otp_prog_reg == 2'h0) || i_otp_lock_bits[i_otp_prog_reg - 2'h1];

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_addr_protected  <= 1'b0;
      o_addr_check_done <= 1'b0;
    end else begin
      o_addr_check_done <= i_addr_check_valid;
      if (i_addr_check_valid) begin
        o_addr_protected <= i_addr_in_map ^ i_inverse_protect;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_otp_prog_accept <= 1'b0;
      o_otp_prog_reject <= 1'b0;
      o_otp_lock_set    <= 3'h0;
    end else begin
      o_otp_prog_accept <= i_otp_prog_valid & ~reg_locked;
      o_otp_prog_reject <= i_otp_prog_valid & reg_locked;
      o_otp_lock_set    <= 3'h0;
      if (i_otp_prog_valid && !reg_locked && i_otp_prog_byte == OTP_LAST_BYTE) begin
        o_otp_lock_set <= 3'h1 << (i_otp_prog_reg - 2'h1);
      end
    end
  end

endmodule : fsr_guard
`default_nettype wire

/* sim/fsr_host_model.sv */
// Serial bus host model that issues status commands to the flash
`timescale 1ns/1ns
`default_nettype none
module fsr_host_model (
  input  wire logic i_sys_clk,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
  // Half of a 64 ns link period
  task automatic half;
    repeat (4) @(negedge i_sys_clk);
  endtask : half
  // Byte MSB first; read late in the high phase, clear of the synchroniser lag
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_si = tx[i];
      half();
      o_sck = 1'b1;
      half();
      rx[i] = i_so_oe ? i_so : 1'b0;
      o_sck = 1'b0;
    end
  endtask : shift
  // One command per frame; clock stands still outside it
  task automatic frame(input logic [7:0] cmd, input logic two, input logic [7:0] dat, output logic [7:0] rx);
    logic [7:0] junk;
    rx = 8'h00;
    @(negedge i_sys_clk);
    o_cs_n = 1'b0;
    half();
    shift(cmd, junk);
    if (two) begin
      shift(dat, rx);
    end
    half();
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    repeat (10) @(negedge i_sys_clk);
  endtask : frame
endmodule : fsr_host_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the second status register block
`timescale 1ns/1ns
`default_nettype none
module testbench
  import fsr_pkg::*;
;
  logic       clk, rst, sck, cs_n, si, so, so_oe, wp_n, hold_n, rsel, jrst, sel_lo, plock;
  logic       chk_v, in_map, otp_v, latch, io2, io3, guard, q_rej, blk, srst, prot, done, acc, rej, hold;
  logic [1:0] otp_r;
  logic [6:0] otp_b;
  logic [7:0] stat, rx;
  logic [2:0] seen;
  int         mismatches = 0;
  int         checks = 0;
  int         cyc = 0;
  fsr_status_two DUT (.i_sys_clk(clk), .i_reset(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .o_so(so), .o_so_oe(so_oe), .i_wp_n(wp_n), .i_hold_n(hold_n), .i_reset_func_sel(rsel),
    .i_jedec_reset(jrst), .i_protect_select_lo(sel_lo), .i_permanent_lock_bit(plock),
    .i_addr_check_valid(chk_v), .i_addr_in_map(in_map), .i_otp_prog_valid(otp_v),
    .i_otp_prog_reg(otp_r), .i_otp_prog_byte(otp_b), .o_status_two(stat), .o_write_latch(latch),
    .o_io2_data_mode(io2), .o_io3_data_mode(io3), .o_write_guard_active(guard), .o_hold_active(hold),
    .o_quad_cmd_reject(q_rej), .o_status_write_blocked(blk), .o_soft_reset(srst),
    .o_addr_protected(prot), .o_addr_check_done(done), .o_otp_prog_accept(acc), .o_otp_prog_reject(rej));
  fsr_host_model host (.i_sys_clk(clk), .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // Sticky capture of one-cycle pulses
  always @(posedge clk) seen <= seen | {srst, blk, q_rej};
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic cmd(input logic [7:0] c);
    host.frame(c, 1'b0, 8'h00, rx);
  endtask : cmd
  task automatic wrs(input logic [7:0] v);
    cmd(CMD_WRITE_ENABLE);
    host.frame(CMD_WRITE_STATUS2, 1'b1, v, rx);
  endtask : wrs
  // Register copy and serial read-back both
  task automatic chk(input logic [7:0] e);
    cmp("status port", e, stat);
    host.frame(CMD_READ_STATUS2, 1'b1, 8'h00, rx);
    cmp("status read", e, rx);
  endtask : chk
  task automatic pins(input logic w, input logic h);
    wp_n   = w;
    hold_n = h;
    repeat (6) @(negedge clk);
  endtask : pins
  task automatic t_reset;
    // Pause pin is low from the start; look at it inside the frame
    fork
      chk(8'h00);
      begin
        repeat (20) @(negedge clk);
        cmp("hold", 8'h01, {7'h00, hold});
      end
    join
    cmp("io2 mode", 8'h00, {7'h00, io2});
    pins(1'b0, 1'b1);
    cmp("guard", 8'h01, {7'h00, guard});
    pins(1'b1, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_write;
    seen = 3'h0;
    host.frame(CMD_WRITE_STATUS2, 1'b1, 8'h42, rx);
    cmp("blocked", 8'h01, {7'h00, seen[1]});
    chk(8'h00);
    wrs(8'hFE);
    chk(8'h42);
    cmp("latch", 8'h00, {7'h00, latch});
    cmp("io modes", 8'h03, {6'h00, io3, io2});
    pins(1'b0, 1'b0);
    cmp("guard", 8'h00, {7'h00, guard});
    chk(8'h42);
    pins(1'b1, 1'b1);
    wrs(8'h00);
    $display("test write done");
  endtask : t_write
  task automatic t_quad;
    logic [7:0] q [6];
    q = '{CMD_QUAD_OUT_READ, CMD_XIP_READ, CMD_XIP_READ_DW, CMD_QUAD_PROGRAM, CMD_BURST_WRAP, CMD_QUAD_ID_READ};
    for (int p = 0; p < 2; p++) begin
      foreach (q[k]) begin
        seen = 3'h0;
        cmd(q[k]);
        cmp("quad reject", {7'h00, p == 0}, {7'h00, seen[0]});
      end
      wrs(8'h02);
    end
    seen = 3'h0;
    cmd(CMD_WRITE_DISABLE);
    cmp("plain cmd", 8'h00, {7'h00, seen[0]});
    wrs(8'h00);
    $display("test quad done");
  endtask : t_quad
  task automatic addr(input logic m, input logic e);
    @(negedge clk);
    chk_v  = 1'b1;
    in_map = m;
    @(negedge clk);
    cmp("check done", 8'h01, {7'h00, done});
    cmp("protected", {7'h00, e}, {7'h00, prot});
    chk_v = 1'b0;
    @(negedge clk);
    cmp("check done", 8'h00, {7'h00, done});
  endtask : addr
  task automatic t_addr;
    addr(1'b1, 1'b1);
    addr(1'b0, 1'b0);
    wrs(8'h40);
    addr(1'b1, 1'b0);
    addr(1'b0, 1'b1);
    wrs(8'h00);
    $display("test address done");
  endtask : t_addr
  task automatic t_suspended_flag;
    for (int k = 0; k < 4; k++) begin
      cmd(CMD_WRITE_ENABLE);
      cmd(CMD_SUSPEND);
      chk(8'h80);
      seen = 3'h0;
      case (k)
        0: cmd(CMD_RESUME);
        1: begin
          cmd(CMD_RESET_ENABLE);
          cmd(CMD_RESET);
          cmp("soft reset", 8'h01, {7'h00, seen[2]});
        end
        2: begin
          jrst = 1'b1;
          @(negedge clk);
          jrst = 1'b0;
        end
        default: begin
          rsel = 1'b1;
          pins(1'b1, 1'b0);
          pins(1'b1, 1'b1);
          rsel = 1'b0;
        end
      endcase
      repeat (4) @(negedge clk);
      chk(8'h00);
      if (k > 0) cmp("latch", 8'h00, {7'h00, latch});
    end
    $display("test suspend done");
  endtask : t_suspended_flag
  task automatic otp(input logic [1:0] r, input logic [6:0] b, input logic a);
    @(negedge clk);
    otp_v = 1'b1;
    otp_r = r;
    otp_b = b;
    @(negedge clk);
    cmp("otp accept", {7'h00, a}, {7'h00, acc});
    cmp("otp reject", {7'h00, !a}, {7'h00, rej});
    otp_v = 1'b0;
    repeat (2) @(negedge clk);
  endtask : otp
  task automatic t_otp;
    otp(2'h1, OTP_LAST_BYTE, 1'b1);
    chk(8'h08);
    otp(2'h1, 7'h00, 1'b0);
    otp(2'h0, 7'h05, 1'b0);
    otp(2'h2, 7'h7E, 1'b1);
    otp(2'h3, OTP_LAST_BYTE, 1'b1);
    otp(2'h3, 7'h10, 1'b0);
    wrs(8'h3C);
    chk(8'h28);
    $display("test otp done");
  endtask : t_otp
  task automatic t_prot;
    sel_lo = 1'b1;
    pins(1'b0, 1'b1);
    seen = 3'h0;
    wrs(8'h40);
    cmp("blocked", 8'h01, {7'h00, seen[1]});
    chk(8'h28);
    pins(1'b1, 1'b1);
    wrs(8'h40);
    chk(8'h68);
    sel_lo = 1'b0;
    wrs(8'h01);
    chk(8'h29);
    wrs(8'h40);
    chk(8'h29);
    cmd(CMD_RESET_ENABLE);
    cmd(CMD_RESET);
    chk(8'h28);
    wrs(8'h40);
    chk(8'h68);
    $display("test protect done");
  endtask : t_prot
  initial begin
    {rst, wp_n, hold_n, rsel, jrst, sel_lo, plock} = 7'h61;
    {chk_v, in_map, otp_v, otp_r, otp_b, seen} = 15'h0000;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    t_reset();
    t_write();
    t_quad();
    t_addr();
    t_suspended_flag();
    t_otp();
    t_prot();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
